// File: logic/rwc_pkg.sv
// constants and types shared by the ramp waveform control block
package rwc_pkg;
   // serial word framing
   localparam int WORD_W = 32;
   localparam int TGT_W = 3;
   localparam logic [2:0] TGT_CLOCK = 3'h4;
   localparam logic [2:0] TGT_DEVIATION = 3'h5;
   localparam logic [2:0] TGT_STEP = 3'h6;
   localparam logic [2:0] TGT_DELAY = 3'h7;
   // ramp_clock_config fields
   localparam int TIMER_LSB = 7;
   localparam int TIMER_W = 12;
   localparam int TIMER_SEL_BIT = 6;
   // frequency_deviation_config fields
   localparam int TRIG_INV_BIT = 30;
   localparam int RAMP_SRC_BIT = 29;
   localparam int PARAB_BIT = 28;
   localparam int IRQ_LSB = 26;
   localparam int IRQ_W = 2;
   localparam int KEY_RAMP_BIT = 25;
   localparam int DUAL_BIT = 24;
   localparam int DEVIATION_SEL_BIT = 23;
   localparam int SHIFT_LSB = 19;
   localparam int SHIFT_W = 4;
   localparam int WORD_LSB = 3;
   localparam int STEPWORD_W = 16;
   // ramp_step_count fields
   localparam int STEP_SEL_BIT = 23;
   localparam int COUNT_LSB = 3;
   localparam int COUNT_W = 20;
   // ramp_delay_config fields
   localparam int TRIG_DLY_BIT = 23;
   localparam int TRI_DLY_BIT = 22;
   localparam int ONE_TRI_BIT = 21;
   localparam int TRIG_START_BIT = 20;
   localparam int FAST_RAMP_BIT = 19;
   localparam int DLY_LOCK_BIT = 18;
   localparam int RAMP_DLY_BIT = 17;
   localparam int DLY_CLK_BIT = 16;
   localparam int DSTART_BIT = 15;
   localparam int DWORD_LSB = 3;
   localparam int DWORD_W = 12;
   // divide value widths
   localparam int INT_W = 12;
   localparam int FRACT_W = 25;
   localparam int N_W = 37;
   // reset values
   localparam logic [11:0] TIMER_RESET = 12'h001;
   localparam logic [19:0] COUNT_RESET = 20'h00001;
   localparam logic [11:0] DWORD_RESET = 12'h001;
   localparam logic [15:0] STEPWORD_RESET = 16'h0000;
   localparam logic [3:0] SHIFT_RESET = 4'h0;
   // ramp mode input encoding
   localparam logic [1:0] MODE_CONT_SAW = 2'h0;
   localparam logic [1:0] MODE_CONT_TRI = 2'h1;
   localparam logic [1:0] MODE_ONE_BURST = 2'h3;
   // interrupt modes: 00 off, 01 capture and go on, 1x capture and halt
   localparam logic [1:0] IRQ_OFF = 2'h0;
   // ramp engine states
   typedef enum logic [2:0] {
      RS_IDLE,
      RS_START_DLY,
      RS_RAMP,
      RS_TRI_DLY,
      RS_RAMP_DLY,
      RS_HOLD
   } rwc_fsm_t;
endpackage

// File: logic/rwc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rwc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // first stage feeds only the second stage
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rwc_sync_state_t;

   rwc_sync_state_t q; // registered state
   rwc_sync_state_t next_q; // next state

   // shift the pin levels through both stages
   always_comb begin
      next_q.s1 = d_i;
      next_q.s2 = q.s1;
   end

   // synchronous reset to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign q_o = q.s2;
endmodule // rwc_sync

// File: logic/rwc_counter.sv
// reloading down counter that pulses once every load_val enables
`timescale 1ns/10ps
module rwc_counter #(
   parameter int W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [W-1:0] load_val_i,
   input wire logic en_i,
   output logic expire_o
);
   typedef struct packed {
      logic [W-1:0] cnt; // enables left in this period
      logic expire; // one-cycle end of period
   } rwc_cnt_state_t;

   rwc_cnt_state_t q; // registered state
   rwc_cnt_state_t next_q; // next state

   // a load value of zero behaves as one, so the period never stalls
   always_comb begin
      next_q = q;
      next_q.expire = 1'b0;
      if (load_i) begin
         next_q.cnt = load_val_i;
      end else if (en_i) begin
         if (q.cnt <= W'(1)) begin
            next_q.expire = 1'b1;
            next_q.cnt = load_val_i;
         end else begin
            next_q.cnt = q.cnt - W'(1);
         end
      end
   end

   // register the whole state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign expire_o = q.expire;
endmodule // rwc_counter

// File: logic/rwc_ramp_ctrl.sv
// ramp waveform control registers, serial loader and ramp engine
`timescale 1ns/10ps
module rwc_ramp_ctrl
   import rwc_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic SER_CLK_I,
   input wire logic SER_DATA_I,
   input wire logic SER_LE_I,
   input wire logic TRIG_I,
   input wire logic PHASE_CMP_TICK_I,
   input wire logic RAMP_EN_I,
   input wire logic [1:0] RAMP_MODE_I,
   input wire logic [11:0] STEP_CLK_DIV_I,
   input wire logic [11:0] INT_BASE_I,
   input wire logic [24:0] FRACT_BASE_I,
   output logic [11:0] INT_DIV_O,
   output logic [24:0] FRACT_DIV_O,
   output logic [11:0] RB_INT_O,
   output logic [24:0] RB_FRACT_O,
   output logic RAMP_DONE_O,
   output logic FAST_LOCK_O,
   output logic RAMP_BUSY_O
);
   typedef struct packed {
      logic [31:0] shift; // serial input shift register
      logic sclk_q; // last synced serial clock
      logic le_q; // last synced load enable
      logic trig_q; // last synced trigger level
      logic ramp_en_q; // last ramp enable level
      logic [11:0] timer_a; // timer divider, standard slot
      logic [11:0] timer_b; // timer divider, second slot
      logic [15:0] word_a; // frequency step word, slot one
      logic [15:0] word_b; // frequency step word, slot two
      logic [3:0] exp_a; // shift exponent, slot one
      logic [3:0] exp_b; // shift exponent, slot two
      logic [19:0] count_a; // step count, slot one
      logic [19:0] count_b; // step count, slot two
      logic trig_inv; // falling edge active
      logic ramp_src; // trigger edges clock the ramp
      logic parab; // parabolic ramp
      logic [1:0] irq_mode; // readback interrupt mode
      logic key_ramp; // keying on top of ramp
      logic dual; // second ramp enabled
      logic trig_dly; // trigger start honours delay
      logic tri_dly; // delay between triangle sections
      logic one_tri; // single full triangle
      logic trig_start; // trigger level starts ramp
      logic fast; // fast return ramp
      logic dly_lock; // fast lock during ramp delay
      logic ramp_dly; // delay between ramps
      logic dly_clk; // delay clock is tick times divider
      logic dstart; // delayed start
      logic [11:0] dword; // delay word for start, triangle and ramp delays
      rwc_fsm_t fsm; // ramp engine state
      logic phase; // 0 first section, 1 second section
      logic reload; // restart timing counters next cycle
      logic [19:0] left; // steps left in this section
      logic [36:0] offset; // ramp offset on divide value
      logic [36:0] slope; // running step for parabolic ramp
      logic [11:0] int_o; // integer divide out
      logic [24:0] fract_o; // fractional divide out
      logic [11:0] rb_int; // captured integer value
      logic [24:0] rb_fract; // captured fractional value
      logic done; // end of ramp pulse
      logic lock; // fast lock level
      logic busy; // ramp or delay in progress
   } rwc_ramp_state_t;

   rwc_ramp_state_t q; // registered state
   rwc_ramp_state_t next_q; // next state
   logic [3:0] pins; // synced serial clock, data, enable, trigger
   logic pre_exp; // step clock divider period end
   logic tmr_exp; // ramp timer period end
   logic dly_exp; // delay period end
   logic timing; // timing counters run
   logic in_dly; // engine waits in a delay state
   logic sclk_rise; // serial clock edge
   logic le_rise; // word complete
   logic trig_lvl; // trigger at its active level
   logic trig_edge; // active trigger edge
   logic step_tick; // one ramp step now
   logic use_b; // section uses second slots
   logic tri_shape; // triangular shape
   logic two_sec; // ramp has a second section
   logic single; // stop after one ramp
   logic [36:0] incr; // shifted step of this section
   logic [36:0] key_incr; // keying deviation
   logic [36:0] n_sum; // base plus offset plus keying

   // pins are asynchronous to the core clock
   rwc_sync #(.W(4)) u_sync (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .d_i({TRIG_I, SER_LE_I, SER_DATA_I, SER_CLK_I}),
      .q_o(pins)
   );

   assign in_dly = (q.fsm == RS_START_DLY) || (q.fsm == RS_TRI_DLY) || (q.fsm == RS_RAMP_DLY);
   assign timing = (q.fsm == RS_RAMP) || in_dly;

   // interval equals divider times timer comparator periods
   rwc_counter #(.W(12)) u_pre (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .load_i(q.reload),
      .load_val_i(STEP_CLK_DIV_I),
      .en_i(PHASE_CMP_TICK_I & timing),
      .expire_o(pre_exp)
   );

   // timer slot follows the current section
   rwc_counter #(.W(12)) u_timer (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .load_i(q.reload),
      .load_val_i(use_b ? q.timer_b : q.timer_a),
      .en_i(pre_exp & (q.fsm == RS_RAMP)),
      .expire_o(tmr_exp)
   );

   // delays count the selected delay clock
   rwc_counter #(.W(12)) u_delay (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .load_i(q.reload),
      .load_val_i(q.dword),
      .en_i(in_dly & (q.dly_clk ? pre_exp : PHASE_CMP_TICK_I)),
      .expire_o(dly_exp)
   );

   // decoded views of the stored configuration
   always_comb begin
      sclk_rise = pins[0] & ~q.sclk_q;
      le_rise = pins[2] & ~q.le_q;
      trig_lvl = pins[3] ^ q.trig_inv;
      trig_edge = q.trig_inv ? (~pins[3] & q.trig_q) : (pins[3] & ~q.trig_q);
      step_tick = q.ramp_src ? trig_edge : tmr_exp;
      tri_shape = (RAMP_MODE_I == MODE_CONT_TRI) || q.one_tri;
      two_sec = tri_shape || q.dual || q.fast;
      single = RAMP_MODE_I[1] || q.one_tri;
      use_b = q.phase & (q.dual | q.fast);
      incr = (use_b ? {{21{q.word_b[15]}}, q.word_b} : {{21{q.word_a[15]}}, q.word_a})
             << (use_b ? q.exp_b : q.exp_a);
      if (q.phase && !use_b) begin
         incr = 37'h0 - incr; // triangle walks back down
      end
      key_incr = ({{21{q.word_b[15]}}, q.word_b} << q.exp_b) & {37{q.key_ramp & trig_lvl}};
      n_sum = {INT_BASE_I, FRACT_BASE_I} + q.offset + key_incr;
   end

   // serial loader and ramp engine
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      next_q.reload = 1'b0;
      next_q.sclk_q = pins[0];
      next_q.le_q = pins[2];
      next_q.trig_q = pins[3];
      next_q.ramp_en_q = RAMP_EN_I;
      // data are taken MSB first on each serial clock rise
      if (sclk_rise) begin
         next_q.shift = {q.shift[30:0], pins[1]};
      end
      // whole word lands when load enable rises
      if (le_rise) begin
         case (q.shift[2:0])
            TGT_CLOCK: begin
               if (q.shift[TIMER_SEL_BIT]) begin
                  next_q.timer_b = q.shift[TIMER_LSB +: TIMER_W];
               end else begin
                  next_q.timer_a = q.shift[TIMER_LSB +: TIMER_W];
               end
            end
            TGT_DEVIATION: begin
               next_q.trig_inv = q.shift[TRIG_INV_BIT];
               next_q.ramp_src = q.shift[RAMP_SRC_BIT];
               next_q.parab = q.shift[PARAB_BIT];
               next_q.irq_mode = q.shift[IRQ_LSB +: IRQ_W];
               next_q.key_ramp = q.shift[KEY_RAMP_BIT];
               next_q.dual = q.shift[DUAL_BIT];
               if (q.shift[DEVIATION_SEL_BIT]) begin
                  next_q.word_b = q.shift[WORD_LSB +: STEPWORD_W];
                  next_q.exp_b = q.shift[SHIFT_LSB +: SHIFT_W];
               end else begin
                  next_q.word_a = q.shift[WORD_LSB +: STEPWORD_W];
                  next_q.exp_a = q.shift[SHIFT_LSB +: SHIFT_W];
               end
            end
            TGT_STEP: begin
               if (q.shift[STEP_SEL_BIT]) begin
                  next_q.count_b = q.shift[COUNT_LSB +: COUNT_W];
               end else begin
                  next_q.count_a = q.shift[COUNT_LSB +: COUNT_W];
               end
            end
            TGT_DELAY: begin
               next_q.trig_dly = q.shift[TRIG_DLY_BIT];
               next_q.tri_dly = q.shift[TRI_DLY_BIT];
               next_q.one_tri = q.shift[ONE_TRI_BIT];
               next_q.trig_start = q.shift[TRIG_START_BIT];
               next_q.fast = q.shift[FAST_RAMP_BIT];
               next_q.dly_lock = q.shift[DLY_LOCK_BIT];
               next_q.ramp_dly = q.shift[RAMP_DLY_BIT];
               next_q.dly_clk = q.shift[DLY_CLK_BIT];
               next_q.dstart = q.shift[DSTART_BIT];
               next_q.dword = q.shift[DWORD_LSB +: DWORD_W];
            end
            default: begin
               // other targets belong to other blocks
            end
         endcase
      end
      // engine
      case (q.fsm)
         RS_IDLE: begin
            next_q.offset = '0;
            next_q.slope = '0;
            next_q.phase = 1'b0;
            next_q.left = q.count_a;
            if (RAMP_EN_I && q.trig_start && trig_lvl) begin
               next_q.reload = 1'b1;
               next_q.fsm = (q.dstart && q.trig_dly) ? RS_START_DLY : RS_RAMP;
            end else if (RAMP_EN_I && !q.ramp_en_q && !q.trig_start) begin
               next_q.reload = 1'b1;
               next_q.fsm = q.dstart ? RS_START_DLY : RS_RAMP;
            end
         end
         RS_START_DLY: begin
            if (dly_exp) begin
               next_q.reload = 1'b1;
               next_q.fsm = RS_RAMP;
            end
         end
         RS_RAMP: begin
            if (trig_edge && q.irq_mode != IRQ_OFF) begin
               next_q.rb_int = q.int_o;
               next_q.rb_fract = q.fract_o;
               if (q.irq_mode[1]) begin
                  next_q.fsm = RS_HOLD;
               end
            end
            if (step_tick && next_q.fsm == RS_RAMP) begin
               if (q.parab) begin
                  next_q.slope = q.slope + incr;
                  next_q.offset = q.offset + q.slope + incr;
               end else begin
                  next_q.offset = q.offset + incr;
               end
               next_q.left = q.left - 20'h00001;
               if (q.left <= 20'h00001) begin
                  next_q.slope = '0;
                  if (!q.phase && two_sec) begin
                     next_q.phase = 1'b1;
                     next_q.left = (q.dual || q.fast) ? q.count_b : q.count_a;
                     next_q.reload = 1'b1;
                     if (tri_shape && q.tri_dly && q.ramp_dly) begin
                        next_q.fsm = RS_TRI_DLY;
                     end
                  end else begin
                     next_q.done = 1'b1;
                     next_q.phase = 1'b0;
                     next_q.left = q.count_a;
                     next_q.reload = 1'b1;
                     if (!two_sec && RAMP_MODE_I != MODE_ONE_BURST) begin
                        next_q.offset = '0; // sawtooth jumps back
                     end
                     if (single) begin
                        next_q.fsm = RS_HOLD;
                     end else if (q.ramp_dly) begin
                        next_q.fsm = RS_RAMP_DLY;
                     end
                  end
               end
            end
         end
         RS_TRI_DLY: begin
            if (dly_exp) begin
               next_q.reload = 1'b1;
               next_q.fsm = RS_RAMP;
            end
         end
         RS_RAMP_DLY: begin
            if (dly_exp) begin
               next_q.reload = 1'b1;
               next_q.fsm = RS_RAMP;
            end
         end
         RS_HOLD: begin
            // final value held until ramp enable drops
         end
         default: begin
            next_q.fsm = RS_IDLE;
         end
      endcase
      if (!RAMP_EN_I) begin
         next_q.fsm = RS_IDLE;
      end
      next_q.lock = (next_q.fsm == RS_RAMP_DLY) && q.dly_lock;
      // busy is registered so the pin never shows decode glitches
      next_q.busy = (next_q.fsm != RS_IDLE) && (next_q.fsm != RS_HOLD);
      next_q.int_o = n_sum[36:25];
      next_q.fract_o = n_sum[24:0];
   end

   // registers hold their reset values until written
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         q <= '0;
         q.timer_a <= TIMER_RESET;
         q.timer_b <= TIMER_RESET;
         q.count_a <= COUNT_RESET;
         q.count_b <= COUNT_RESET;
         q.dword <= DWORD_RESET;
         q.word_a <= STEPWORD_RESET;
         q.word_b <= STEPWORD_RESET;
         q.exp_a <= SHIFT_RESET;
         q.exp_b <= SHIFT_RESET;
         q.fsm <= RS_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign INT_DIV_O = q.int_o;
   assign FRACT_DIV_O = q.fract_o;
   assign RB_INT_O = q.rb_int;
   assign RB_FRACT_O = q.rb_fract;
   assign RAMP_DONE_O = q.done;
   assign FAST_LOCK_O = q.lock;
   assign RAMP_BUSY_O = q.busy;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   // a word ready at the load enable edge
   sequence s_word(logic [2:0] tgt);
      le_rise && q.shift[2:0] == tgt;
   endsequence

   property p_delay_load;
      s_word(TGT_DELAY) |=> q.dword == $past(q.shift[DWORD_LSB +: DWORD_W]);
   endproperty
   a_delay_load: assert property (p_delay_load) else $error("delay word not loaded");

   property p_timer_slot;
      s_word(TGT_CLOCK) ##0 q.shift[TIMER_SEL_BIT]
         |=> q.timer_b == $past(q.shift[TIMER_LSB +: TIMER_W]) && $stable(q.timer_a);
   endproperty
   a_timer_slot: assert property (p_timer_slot) else $error("timer slot misrouted");

   property p_word_slot;
      s_word(TGT_DEVIATION) ##0 !q.shift[DEVIATION_SEL_BIT]
         |=> q.word_a == $past(q.shift[WORD_LSB +: STEPWORD_W]) && $stable(q.word_b);
   endproperty
   a_word_slot: assert property (p_word_slot) else $error("deviation slot misrouted");

   property p_count_slot;
      s_word(TGT_STEP) ##0 q.shift[STEP_SEL_BIT]
         |=> q.count_b == $past(q.shift[COUNT_LSB +: COUNT_W]) && $stable(q.count_a);
   endproperty
   a_count_slot: assert property (p_count_slot) else $error("step slot misrouted");

   property p_step_add;
      q.fsm == RS_RAMP && step_tick && !q.parab && q.left > 20'h00001 && q.irq_mode == IRQ_OFF
         |=> q.offset == $past(q.offset) + $past(incr);
   endproperty
   a_step_add: assert property (p_step_add) else $error("ramp step not added");

   property p_irq_halt;
      q.fsm == RS_RAMP && trig_edge && q.irq_mode[1] && RAMP_EN_I
         |=> q.fsm == RS_HOLD && q.rb_int == $past(q.int_o) ##1 q.fsm == RS_HOLD || !$past(RAMP_EN_I);
   endproperty
   a_irq_halt: assert property (p_irq_halt) else $error("interrupt halt failed");

   property p_trig_start;
      q.fsm == RS_IDLE && RAMP_EN_I && q.trig_start && trig_lvl
         |=> q.fsm == (($past(q.dstart) && $past(q.trig_dly)) ? RS_START_DLY : RS_RAMP);
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger start wrong");

   property p_edge_clock;
      q.fsm == RS_RAMP && q.ramp_src && !trig_edge |=> $stable(q.offset);
   endproperty
   a_edge_clock: assert property (p_edge_clock) else $error("ramp moved without trigger edge");

   property p_fast_lock;
      q.fsm == RS_RAMP_DLY && q.dly_lock && RAMP_EN_I && !dly_exp |=> FAST_LOCK_O;
   endproperty
   a_fast_lock: assert property (p_fast_lock) else $error("fast lock missing in delay");
endmodule // rwc_ramp_ctrl

// File: bench/rwc_host.sv
// host side serial writer for the ramp control registers
`timescale 1ns/10ps
module rwc_host (
   input wire logic clk_i,
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic ser_le_o
);
   // idle levels: clock and load low
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      ser_le_o = 1'b0;
   end
   // each level held three core cycles so the synchroniser sees it
   task automatic hold3();
      repeat (3) @(negedge clk_i);
   endtask
   // msb first, 32 bits, then a load pulse
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         ser_data_o = w[i];
         hold3();
         ser_clk_o = 1'b1;
         hold3();
         ser_clk_o = 1'b0;
      end
      hold3();
      ser_le_o = 1'b1;
      hold3();
      ser_le_o = 1'b0;
      // released data line must not keep showing the last bit
      ser_data_o = ~w[0];
      // let the inverted level stand before the next word drives data
      hold3();
   endtask
endmodule // rwc_host

// File: bench/rwc_ramp_ctrl_test.sv
// self-checking bench for the ramp waveform control block
`timescale 1ns/10ps
module rwc_ramp_ctrl_test;
   import rwc_pkg::*;
   logic clk, rst, sck, sdat, sle, en;
   logic tick = 1'b0;
   logic trig = 1'b0; // trigger pin, idle at its inactive level
   logic [1:0] mode = MODE_ONE_BURST; // burst holds final value
   logic [11:0] div, ib, int_o, rbi;
   logic [24:0] fb, fr_o, rbf;
   logic done, fl, busy;
   int n_fail = 0;
   int checked = 0;
   int seed = 73;
   int cyc = 0;
   // clock at 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // random comparator ticks vary the step timing, not the end value
   always @(negedge clk) tick <= 1'($random(seed));
   rwc_host host (.clk_i(clk), .ser_clk_o(sck), .ser_data_o(sdat), .ser_le_o(sle));
   rwc_ramp_ctrl DUT (.CLOCK_I(clk), .RST_I(rst), .SER_CLK_I(sck), .SER_DATA_I(sdat), .SER_LE_I(sle),
      .TRIG_I(trig), .PHASE_CMP_TICK_I(tick), .RAMP_EN_I(en), .RAMP_MODE_I(mode), .STEP_CLK_DIV_I(div),
      .INT_BASE_I(ib), .FRACT_BASE_I(fb), .INT_DIV_O(int_o), .FRACT_DIV_O(fr_o), .RB_INT_O(rbi),
      .RB_FRACT_O(rbf), .RAMP_DONE_O(done), .FAST_LOCK_O(fl), .RAMP_BUSY_O(busy));
   // compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         results();
      end
   end
   // main sequence: program, ramp, compare with the model
   initial begin
      logic [15:0] wa;
      logic [3:0] sh;
      logic [19:0] cnt;
      longint off;
      logic [36:0] nexp;
      int pulses;
      rst = 1'b1;
      en = 1'b0;
      div = 12'h001;
      ib = 12'h000;
      fb = 25'h0000000;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int k = 0; k < 4; k++) begin
         wa = 16'($random(seed));
         sh = 4'($random(seed)) & 4'h7;
         cnt = 20'(($random(seed) & 7) + 1);
         div = 12'(($random(seed) & 3) + 1);
         ib = 12'($random(seed));
         fb = 25'($random(seed));
         // power-up order: delay, step, deviation, clock, each slot a then b
         host.send(32'h0000000F);
         host.send({8'h00, 1'b0, cnt, 3'h6});
         host.send({8'h00, 1'b1, 20'($random(seed)), 3'h6});
         host.send({8'h00, 1'b0, sh, wa, 3'h5});
         host.send({8'h00, 1'b1, 4'($random(seed)), 16'($random(seed)), 3'h5});
         host.send({13'h0000, 12'h001, 1'b0, 3'h0, 3'h4});
         host.send({13'h0000, 12'h001, 1'b1, 3'h0, 3'h4});
         // low target codes must change nothing
         host.send({29'($random(seed)), 1'b0, 2'($random(seed))});
         repeat (8) @(negedge clk);
         en = 1'b1;
         pulses = 0;
         repeat (2000) begin
            @(negedge clk);
            if (done === 1'b1)
               pulses++;
         end
         // model: count steps of signed word shifted by exponent
         off = longint'($signed(wa)) * (longint'(1) << sh) * longint'(cnt);
         nexp = {ib, fb} + 37'(off);
         check(64'(pulses), 64'h1);
         check(64'({int_o, fr_o}), 64'(nexp));
         en = 1'b0;
         repeat (4) @(negedge clk);
         check(64'({int_o, fr_o}), 64'({ib, fb}));
      end
      // trigger pin: polarity, pin start, edge-clocked steps, readback, fast lock
      for (int v = 0; v < 2; v++) begin
         trig = v[0];
         ib = 12'($random(seed));
         fb = 25'($random(seed));
         mode = v ? MODE_ONE_BURST : MODE_CONT_SAW;
         // pin start, fast lock in a long ramp delay, delay word 0xFF
         host.send({8'h00, 9'b000101100, 12'h0FF, 3'h7});
         host.send({8'h00, 1'b0, 20'h00003, 3'h6});
         // edge clocked, invert v, interrupt continue (v=0) or halt (v=1), step 0x40 << 1
         host.send({1'b0, v[0], 1'b1, 1'b0, v[0], 1'b1, 3'h0, 4'h1, 16'h0040, 3'h5});
         repeat (8) @(negedge clk);
         en = 1'b1;
         repeat (4) @(negedge clk);
         check(64'(busy), 64'h0);
         // first active level starts, next three active edges step or halt
         for (int e = 0; e < 4; e++) begin
            trig = ~v[0];
            repeat (6) @(negedge clk);
            if (e == 0)
               check(64'(busy), 64'h1);
            trig = v[0];
            repeat (6) @(negedge clk);
         end
         // continue: third edge reads two steps; halt: first edge reads base
         nexp = {ib, fb} + (v ? 37'h0 : 37'h100);
         check(64'({rbi, rbf}), 64'(nexp));
         check(64'({int_o, fr_o}), 64'({ib, fb}));
         check(64'(fl), 64'(1 - v));
         check(64'(busy), 64'(1 - v));
         en = 1'b0;
         repeat (4) @(negedge clk);
      end
      results();
   end
endmodule // rwc_ramp_ctrl_test
